// ==== nfh_pkg.sv ====
// package for the nand flash host controller: command codes, geometry, pin timing, register map
// assumes a 100 MHz clk_sys and an axi4-lite master with 32-bit data
package nfh_pkg;
    localparam int CLK_MHZ = 100;
    // pin timing in ns
    localparam int T_WP_NS = 25;
    localparam int T_WH_NS = 15;
    localparam int T_RP_NS = 35;
    localparam int T_RD_ACCESS_NS = 35;
    localparam int T_WHR_NS = 30;
    localparam int T_WB_NS = 200;
    localparam int T_WW_NS = 100;
    function automatic int ns2cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int CYC_WP = ns2cyc(T_WP_NS);
    localparam int CYC_WH = ns2cyc(T_WH_NS);
    localparam int CYC_RP = ns2cyc(T_RP_NS + 10);
    localparam int CYC_REH = ns2cyc(T_WHR_NS);
    localparam int CYC_WB = ns2cyc(T_WB_NS);
    localparam int CYC_WW = ns2cyc(T_WW_NS);
    localparam int CNT_W = 6;
    // command codes
    localparam logic [7:0] CMD_READ1 = 8'h00;
    localparam logic [7:0] CMD_READ2 = 8'h01;
    localparam logic [7:0] CMD_READ3 = 8'h50;
    localparam logic [7:0] CMD_SERIN = 8'h80;
    localparam logic [7:0] CMD_PROG = 8'h10;
    localparam logic [7:0] CMD_ERASE1 = 8'h60;
    localparam logic [7:0] CMD_ERASE2 = 8'hd0;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_ID = 8'h90;
    localparam logic [7:0] CMD_RESET = 8'hff;
    // geometry
    localparam int PAGE_BYTES = 528;
    localparam int MAIN_BYTES = 512;
    localparam int SPARE_BYTES = 16;
    localparam int HALF_COL = 256;
    localparam int PAGES_PER_BLK = 32;
    localparam int BLOCKS = 2048;
    localparam int PAGE_ADR_W = 16;
    localparam int BLK_LSB = 5;
    // register map (byte offsets)
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_ADDR = 5'h04;
    localparam logic [4:0] REG_WDATA = 5'h08;
    localparam logic [4:0] REG_RDATA = 5'h0c;
    localparam logic [4:0] REG_STAT = 5'h10;
    localparam logic [4:0] REG_WP = 5'h14;
    // ctrl fields
    localparam int CTRL_CMD_LSB = 0;
    localparam int CTRL_OP_LSB = 8;
    localparam int CTRL_NADR_LSB = 12;
    // host operations
    localparam logic [3:0] OP_CMD = 4'h1;
    localparam logic [3:0] OP_ADR = 4'h2;
    localparam logic [3:0] OP_WR = 4'h3;
    localparam logic [3:0] OP_RD = 4'h4;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_SETUP = 6'b000010,
        ST_WLOW = 6'b000100,
        ST_WHIGH = 6'b001000,
        ST_RLOW = 6'b010000,
        ST_RHIGH = 6'b100000
    } nfh_state_e;
endpackage

// ==== nfh_sync.sv ====
// two-flop synchroniser for a pin level
// assumes the input is asynchronous to clk_sys
`timescale 1ns/10ps
module nfh_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [W-1:0] pinIn, // asynchronous level
    output logic [W-1:0] syncOut // level in clk_sys domain
);
    logic [W-1:0] meta_ff;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // pins idle high; resetting to one avoids a false busy level after reset
            meta_ff <= '1;
            syncOut <= '1;
        end else begin
            meta_ff <= pinIn;
            syncOut <= meta_ff;
        end
    end
endmodule

// ==== nfh_host.sv ====
// host controller for a nand flash: drives the strobes and the shared io bus, axi4-lite slave for software
// assumes the flash pins are asynchronous and ready_busy_n is pulled up outside (open drain)
`timescale 1ns/10ps
module nfh_host
    import nfh_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [4:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [4:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    output logic cmdLatch, // command latch strobe
    output logic addrLatch, // address latch strobe
    output logic chipSel_n, // chip select, active low
    output logic writeStrobe_n, // write strobe, active low
    output logic read_strobe_n, // read strobe, active low
    output logic writeProt_n, // write protect, active low
    output logic [15:0] ioOut, // io bus drive value
    output logic ioOe_n, // io bus enable, low drives
    input wire logic [15:0] ioIn, // io bus sampled
    input wire logic ready_busy_n // open-drain ready/busy
);
    import nfh_pkg::*;

    nfh_state_e state_ff, nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [7:0] cmd_ff;
    logic [3:0] op_ff;
    logic [1:0] nAdr_ff, adrIdx_ff;
    logic [23:0] addr_ff;
    logic [15:0] wdata_ff, rdata_ff;
    logic halfSel_ff, busy_ff, wpReg_ff, wideBus_ff, cmdErr_ff, chipSel_ff;
    logic pinSync;
    logic ready, rbPrev_ff;
    logic awHeld_ff, wHeld_ff;
    logic [4:0] awAddr_ff;
    logic [31:0] wData_ff;
    logic [3:0] wStrb_ff;

    nfh_sync #(.W(1)) uSync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pinIn(ready_busy_n),
        .syncOut(pinSync)
    );
    assign ready = pinSync;

    function automatic logic cmdAllowedBusy(input logic [7:0] c);
        return (c == CMD_STATUS) || (c == CMD_RESET);
    endfunction

    function automatic logic cmdKnown(input logic [7:0] c, input logic wide);
        case (c)
            CMD_READ1, CMD_READ3, CMD_SERIN, CMD_PROG, CMD_ERASE1, CMD_ERASE2,
            CMD_STATUS, CMD_ID, CMD_RESET: return 1'b1;
            CMD_READ2: return !wide;
            default: return 1'b0;
        endcase
    endfunction

    // axi write path: address and data accepted in either order
    wire wrGo = awHeld_ff && wHeld_ff && !s_axi_bvalid;
    assign s_axi_awready = !awHeld_ff && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_ff && !s_axi_bvalid;
    wire opStart = wrGo && awAddr_ff == REG_CTRL && state_ff == ST_IDLE;
    wire [7:0] newCmd = wData_ff[CTRL_CMD_LSB +: 8];
    wire [3:0] newOp = wData_ff[CTRL_OP_LSB +: 4];
    // a busy device sees only status and reset commands
    wire cmdOk = !(newOp == OP_CMD) ||
                 (cmdKnown(newCmd, wideBus_ff) && (ready || cmdAllowedBusy(newCmd)));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            awAddr_ff <= '0;
            wData_ff <= '0;
            wStrb_ff <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_ff <= 1'b1;
                awAddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_ff <= 1'b1;
                wData_ff <= s_axi_wdata;
                // strobes travel with the data; the master may change them once w is taken
                wStrb_ff <= s_axi_wstrb;
            end
            if (wrGo) begin
                awHeld_ff <= 1'b0;
                wHeld_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= RESP_OKAY;
                // ctrl while a cycle runs, or an illegal command, is refused
                if (awAddr_ff == REG_CTRL && (state_ff != ST_IDLE || !cmdOk))
                    s_axi_bresp <= RESP_SLVERR;
                else if (awAddr_ff > REG_WP || awAddr_ff[1:0] != 2'b00)
                    s_axi_bresp <= RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // software registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            addr_ff <= '0;
            wdata_ff <= '0;
            wpReg_ff <= 1'b0;
            wideBus_ff <= 1'b0;
            chipSel_ff <= 1'b0;
        end else if (wrGo && wStrb_ff != 4'h0) begin
            case (awAddr_ff)
                REG_ADDR: addr_ff <= wData_ff[23:0];
                REG_WDATA: wdata_ff <= wData_ff[15:0];
                REG_WP: begin
                    wpReg_ff <= wData_ff[0];
                    wideBus_ff <= wData_ff[1];
                    chipSel_ff <= wData_ff[2];
                end
                default: ;
            endcase
        end
    end

    // pin cycle engine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: if (opStart && cmdOk && newOp != 4'h0) nxt_state = ST_SETUP;
            ST_SETUP: if (cnt_ff == '0) nxt_state = (op_ff == OP_RD) ? ST_RLOW : ST_WLOW;
            ST_WLOW: if (cnt_ff == '0) nxt_state = ST_WHIGH;
            ST_WHIGH: if (cnt_ff == '0) nxt_state = (op_ff == OP_ADR && adrIdx_ff != nAdr_ff) ? ST_WLOW : ST_IDLE;
            ST_RLOW: if (cnt_ff == '0) nxt_state = ST_RHIGH;
            ST_RHIGH: if (cnt_ff == '0) nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
            op_ff <= '0;
            cmd_ff <= '0;
            nAdr_ff <= '0;
            adrIdx_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            if (cnt_ff != '0)
                cnt_ff <= cnt_ff - 1'b1;
            case (state_ff)
                ST_IDLE: if (nxt_state == ST_SETUP) begin
                    op_ff <= newOp;
                    cmd_ff <= newCmd;
                    nAdr_ff <= wData_ff[CTRL_NADR_LSB +: 2];
                    adrIdx_ff <= '0;
                    // write protect must be high ahead of a data-in strobe
                    cnt_ff <= (newOp == OP_WR) ? CNT_W'(CYC_WW) : CNT_W'(CYC_WH);
                end
                ST_SETUP, ST_WHIGH: if (cnt_ff == '0 && nxt_state == ST_WLOW) begin
                    cnt_ff <= CNT_W'(CYC_WP);
                    adrIdx_ff <= adrIdx_ff + 1'b1;
                end else if (cnt_ff == '0 && nxt_state == ST_RLOW)
                    cnt_ff <= CNT_W'(CYC_RP);
                ST_WLOW: if (cnt_ff == '0)
                    cnt_ff <= (op_ff == OP_CMD) ? CNT_W'(CYC_WB) : CNT_W'(CYC_WH);
                ST_RLOW: if (cnt_ff == '0)
                    cnt_ff <= CNT_W'(CYC_REH);
                default: ;
            endcase
        end
    end

    // pins
    wire wrPhase = (state_ff == ST_SETUP && op_ff != OP_RD) || state_ff == ST_WLOW || state_ff == ST_WHIGH;
    wire [7:0] adrByte = (adrIdx_ff == 2'd1) ? addr_ff[7:0] :
                         (adrIdx_ff == 2'd2) ? addr_ff[15:8] : addr_ff[23:16];
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmdLatch <= 1'b0;
            addrLatch <= 1'b0;
            writeStrobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
            ioOut <= '0;
            ioOe_n <= 1'b1;
        end else begin
            cmdLatch <= wrPhase && op_ff == OP_CMD;
            addrLatch <= wrPhase && op_ff == OP_ADR;
            writeStrobe_n <= !(nxt_state == ST_WLOW);
            read_strobe_n <= !(nxt_state == ST_RLOW);
            ioOe_n <= !wrPhase;
            if (op_ff == OP_CMD)
                ioOut <= {8'h00, cmd_ff};
            else if (op_ff == OP_ADR)
                ioOut <= {8'h00, adrByte};
            else
                ioOut <= wideBus_ff ? wdata_ff : {8'h00, wdata_ff[7:0]};
        end
    end
    // chip select held low unless software parks it and the device is ready
    assign chipSel_n = chipSel_ff && ready;
    assign writeProt_n = wpReg_ff;

    // data sampled at read strobe rise, past the access delay; device advances its column itself
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= '0;
            halfSel_ff <= 1'b0;
            busy_ff <= 1'b0;
            cmdErr_ff <= 1'b0;
            rbPrev_ff <= 1'b1;
        end else begin
            rbPrev_ff <= ready;
            if (state_ff == ST_RLOW && cnt_ff == '0)
                rdata_ff <= wideBus_ff ? ioIn : {8'h00, ioIn[7:0]};
            if (state_ff == ST_IDLE && nxt_state == ST_SETUP && newOp == OP_CMD) begin
                if (newCmd == CMD_READ1 || newCmd == CMD_READ3)
                    halfSel_ff <= 1'b0;
                else if (newCmd == CMD_READ2)
                    halfSel_ff <= 1'b1;
            end
            busy_ff <= !ready;
            if (opStart && !cmdOk)
                cmdErr_ff <= 1'b1;
            else if (wrGo && awAddr_ff == REG_STAT)
                cmdErr_ff <= 1'b0;
        end
    end

    // axi read path
    logic [31:0] rdMux;
    always_comb begin
        rdMux = '0;
        case (s_axi_araddr)
            REG_CTRL: rdMux = {16'h0, 4'h0, op_ff, cmd_ff};
            REG_ADDR: rdMux = {8'h0, addr_ff};
            REG_WDATA: rdMux = {16'h0, wdata_ff};
            REG_RDATA: rdMux = {16'h0, rdata_ff};
            REG_STAT: rdMux = {27'h0, cmdErr_ff, halfSel_ff, rbPrev_ff, busy_ff, state_ff != ST_IDLE};
            REG_WP: rdMux = {29'h0, chipSel_ff, wideBus_ff, wpReg_ff};
            default: rdMux = '0;
        endcase
    end
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= (s_axi_araddr > REG_WP || s_axi_araddr[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ==== nfh_host_checker.sv ====
// assertions on the flash pins and read answer of nfh_host
// assumes it is bound into nfh_host and sees only its ports
`timescale 1ns/10ps
module nfh_host_checker (
    input wire logic clk_sys, // clock
    input wire logic rst_n, // reset
    input wire logic cmdLatch, // command latch
    input wire logic addrLatch, // address latch
    input wire logic chipSel_n, // chip select
    input wire logic writeStrobe_n, // write strobe
    input wire logic read_strobe_n, // read strobe
    input wire logic [15:0] ioOut, // bus value
    input wire logic ioOe_n, // bus enable
    input wire logic ready_busy_n, // ready pin
    input wire logic s_axi_arvalid, // read address valid
    input wire logic s_axi_arready, // read address ready
    input wire logic s_axi_rvalid // read data valid
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_oneLatch; !(cmdLatch && addrLatch); endproperty
    a_oneLatch: assert property (p_oneLatch) else $error("both latches high");
    property p_strobeSel; !writeStrobe_n |-> !chipSel_n && read_strobe_n; endproperty
    a_strobeSel: assert property (p_strobeSel) else $error("write strobe bad pins");
    property p_upperLow; (cmdLatch || addrLatch) && !ioOe_n |-> ioOut[15:8] == 8'h00; endproperty
    a_upperLow: assert property (p_upperLow) else $error("upper lines not low");
    property p_readFree; !read_strobe_n |-> ioOe_n && !cmdLatch && !addrLatch && writeStrobe_n; endproperty
    a_readFree: assert property (p_readFree) else $error("bus fight in read");
    property p_cmdHeld; cmdLatch && !writeStrobe_n |=> cmdLatch; endproperty
    a_cmdHeld: assert property (p_cmdHeld) else $error("command latch dropped early");
    property p_adrHeld; addrLatch && !writeStrobe_n |=> addrLatch; endproperty
    a_adrHeld: assert property (p_adrHeld) else $error("address latch dropped early");
    property p_wrPulse; $fell(writeStrobe_n) |-> !writeStrobe_n [*3]; endproperty
    a_wrPulse: assert property (p_wrPulse) else $error("write pulse short");
    property p_rdPulse; $fell(read_strobe_n) |-> !read_strobe_n [*5]; endproperty
    a_rdPulse: assert property (p_rdPulse) else $error("read pulse short");
    property p_dataHeld; $rose(writeStrobe_n) |-> !$past(ioOe_n) && $stable(ioOut); endproperty
    a_dataHeld: assert property (p_dataHeld) else $error("bus moved at strobe rise");
    property p_busySel; !ready_busy_n [*3] |-> !chipSel_n; endproperty
    a_busySel: assert property (p_busySel) else $error("select released while busy");
    property p_rNext; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rNext: assert property (p_rNext) else $error("read answer late");
endmodule
bind nfh_host nfh_host_checker u_chk (.*);

// ==== nfh_flash_model.sv ====
// behavioural nand flash: latches, read-out, busy, status and id
// assumes the bench resolves the io bus and pulls ready_busy_n up
`timescale 1ns/10ps
module nfh_flash_model #(
    parameter int BUSY_NS = 2000, // array busy time, kept short
    parameter logic [7:0] ID_A = 8'h5a, // arbitrary id value
    parameter logic [7:0] ID_B = 8'h3c // arbitrary id value
) (
    input wire logic cmdLatch, // command latch
    input wire logic addrLatch, // address latch
    input wire logic chipSel_n, // chip select
    input wire logic writeStrobe_n, // write strobe
    input wire logic read_strobe_n, // read strobe
    input wire logic writeProt_n, // write protect
    input wire logic [15:0] ioIn, // resolved bus
    output logic [15:0] devOut, // value driven when enabled
    output logic devOe, // device drives the bus
    output logic busyPull // pulls ready_busy_n low
);
    logic [7:0] cmd;
    logic [23:0] adr;
    logic [9:0] col;
    int nAdr;
    logic [4:0] pgIdx;
    logic [10:0] blk;
    assign pgIdx = adr[12:8];
    assign blk = adr[23:13];
    initial begin
        {cmd, adr, col, devOut, busyPull} = '0;
        nAdr = 0;
    end
    assign devOe = !read_strobe_n && !chipSel_n && !cmdLatch && !addrLatch;
    task automatic goBusy;
        busyPull = 1'b1;
        busyPull <= #(BUSY_NS) 1'b0;
    endtask
    always @(posedge writeStrobe_n) begin
        if (!chipSel_n && cmdLatch) begin
            cmd = ioIn[7:0];
            nAdr = 0;
            if ((cmd == 8'h10 || cmd == 8'hd0) && writeProt_n) goBusy();
        end else if (!chipSel_n && addrLatch) begin
            adr[8*nAdr +: 8] = ioIn[7:0];
            nAdr++;
            if (nAdr == 1) col = cmd == 8'h50 ? {6'h20, adr[3:0]} : {1'b0, cmd == 8'h01, adr[7:0]};
            if (nAdr == 3 && cmd inside {8'h00, 8'h01, 8'h50}) goBusy();
        end
    end
    // data appears an access delay after the fall, so a host sampling too early sees the old value
    always @(negedge read_strobe_n) begin
        if (!chipSel_n) begin
            devOut <= #20 cmd == 8'h70 ? {8'h00, writeProt_n, !busyPull, 6'h00} :
                cmd == 8'h90 ? {8'h00, col[0] ? ID_B : ID_A} :
                {8'h00, ({blk[2:0], pgIdx} ^ blk[10:3]) + col[7:0] + {col[9:8], 6'h11}};
            if (cmd != 8'h70 && col != 10'd527) col++;
        end
    end
endmodule

// ==== tb_top.sv ====
// self-checking bench for nfh_host against the behavioural flash, driven over axi4-lite
// assumes nfh_pkg, nfh_host, the flash model and the checker are compiled first
`timescale 1ns/10ps
module tb_top;
    import nfh_pkg::*;
    logic clk_sys, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ready_busy_n;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic cmdLatch, addrLatch, chipSel_n, writeStrobe_n, read_strobe_n, writeProt_n, ioOe_n, devOe, busyPull;
    logic [15:0] ioOut, ioIn, devOut, lastBus, pg;
    logic [9:0] c;
    logic [7:0] mode, cb, b;
    int mismatches, comparisons, seed;
    // a released bus shows the inverse of its last value, so stale data cannot pass
    assign ioIn = !ioOe_n ? ioOut : devOe ? devOut : ~lastBus;
    always @(ioIn) if (!ioOe_n || devOe) lastBus = ioIn;
    assign ready_busy_n = !busyPull;
    nfh_host dut (.*, .s_axi_wstrb(4'hf));
    nfh_flash_model u_flash (.*);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic axiWr(input logic [4:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ta, tw, tb;
        {ta, tw, tb} = 3'b000;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        while (!tb) begin
            @(negedge clk_sys);
            ta = ta | (s_axi_awvalid & s_axi_awready);
            tw = tw | (s_axi_wvalid & s_axi_wready);
            tb = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge clk_sys);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic axiRd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ta, tr;
        {ta, tr} = 2'b00;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        while (!tr) begin
            @(negedge clk_sys);
            ta = ta | (s_axi_arvalid & s_axi_arready);
            tr = s_axi_rvalid;
            {v, rs} = {s_axi_rdata, s_axi_rresp};
            @(posedge clk_sys);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
    task automatic op(input logic [3:0] o, input logic [7:0] cm, input logic [1:0] n, output logic [1:0] rs);
        logic [31:0] s;
        logic [1:0] x;
        axiWr(REG_CTRL, {18'h0, n, o, cm}, rs);
        s = 32'h1;
        while (s[0] !== 1'b0) axiRd(REG_STAT, s, x);
    endtask
    task automatic cmdAdr(input logic [7:0] cm, input logic [23:0] a, input logic [1:0] n);
        op(OP_CMD, cm, 2'd0, r);
        check({6'h0, r}, {6'h0, RESP_OKAY});
        axiWr(REG_ADDR, {8'h0, a}, r);
        op(OP_ADR, 8'h00, n, r);
    endtask
    task automatic rdByte(output logic [7:0] v);
        op(OP_RD, 8'h00, 2'd0, r);
        axiRd(REG_RDATA, d, r);
        v = d[7:0];
    endtask
    task automatic waitReady;
        @(posedge clk_sys);
        while (ready_busy_n !== 1'b1) @(posedge clk_sys);
    endtask
    initial begin
        repeat (60000) @(posedge clk_sys);
        mismatches++;
        give_verdict;
    end
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, lastBus} = '0;
        {mismatches, comparisons, seed} = {32'd0, 32'd0, 32'd5926};
        rst_n = 1'b0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        check({7'h0, writeProt_n}, 8'h00);
        axiRd(5'h18, d, r);
        check({6'h0, r}, {6'h0, RESP_SLVERR});
        axiWr(REG_WP, 32'h1, r);
        for (int i = 0; i < 9; i++) begin
            mode = i % 3 == 0 ? CMD_READ1 : i % 3 == 1 ? CMD_READ2 : CMD_READ3;
            cb = i == 8 ? 8'h0f : 8'($random(seed));
            pg = 16'($random(seed));
            cmdAdr(mode, {pg, cb}, 2'd3);
            waitReady;
            axiRd(REG_STAT, d, r);
            check({7'h0, d[3]}, {7'h0, mode == CMD_READ2});
            for (int k = 0; k < 3; k++) begin
                c = (mode == CMD_READ3 ? {6'h20, cb[3:0]} : {1'b0, mode == CMD_READ2, cb}) + 10'(k);
                c = c > 10'd527 ? 10'd527 : c;
                rdByte(b);
                check(b, (pg[7:0] ^ pg[15:8]) + c[7:0] + {c[9:8], 6'h11});
            end
        end
        // park chip select while the device is busy: it must stay low until ready
        cmdAdr(CMD_READ1, 24'h000000, 2'd3);
        axiWr(REG_WP, 32'h5, r);
        check({7'h0, chipSel_n}, 8'h00);
        waitReady;
        repeat (3) @(posedge clk_sys);
        check({7'h0, chipSel_n}, 8'h01);
        axiWr(REG_WP, 32'h1, r);
        check({7'h0, chipSel_n}, 8'h00);
        op(OP_CMD, 8'h33, 2'd0, r);
        check({6'h0, r}, {6'h0, RESP_SLVERR});
        axiRd(REG_STAT, d, r);
        check({3'h0, d[4:0]}, 8'h14);
        axiWr(REG_WP, 32'h3, r);
        op(OP_CMD, CMD_READ2, 2'd0, r);
        check({6'h0, r}, {6'h0, RESP_SLVERR});
        for (int k = 0; k < 2; k++) begin
            // second pass runs wide, so upper data lines carry data before a command cycle
            axiWr(REG_WP, 32'(k * 3), r);
            cmdAdr(CMD_SERIN, 24'h000100, 2'd3);
            axiWr(REG_WDATA, 32'h00005aa5, r);
            op(OP_WR, 8'h00, 2'd0, r);
            op(OP_CMD, CMD_PROG, 2'd0, r);
            check({7'h0, ready_busy_n}, {7'h0, k == 0});
            waitReady;
        end
        cmdAdr(CMD_ERASE1, 24'h000020, 2'd2);
        op(OP_CMD, CMD_ERASE2, 2'd0, r);
        op(OP_CMD, CMD_READ1, 2'd0, r);
        check({6'h0, r}, {6'h0, RESP_SLVERR});
        op(OP_CMD, CMD_STATUS, 2'd0, r);
        rdByte(b);
        check(b, 8'h80);
        waitReady;
        rdByte(b);
        check(b, 8'hc0);
        cmdAdr(CMD_ID, 24'h0, 2'd1);
        rdByte(b);
        check(b, 8'h5a);
        rdByte(b);
        check(b, 8'h3c);
        op(OP_CMD, CMD_RESET, 2'd0, r);
        check({6'h0, r}, {6'h0, RESP_OKAY});
        give_verdict;
    end
endmodule
